// ---- hdl/vam_ip_cmp.sv ----
// vam_ip_cmp: one ipv4 address criterion, any / host / network.
// assumes mode, address and mask are held stable by the register file.
`timescale 1ns/1ps
module vam_ip_cmp
  import vam_pkg::*;
(
  // criterion setting
  input  wire logic [1:0]  mode,
  input  wire logic [31:0] cfg_addr,
  input  wire logic [31:0] cfg_mask,
  // frame field
  input  wire logic [31:0] frm_addr,
  // result
  output logic             match
);

  logic host_eq;
  logic net_eq;

  assign host_eq = (frm_addr == cfg_addr);
  // network compare on masked address
  assign net_eq  = ((frm_addr & cfg_mask) == (cfg_addr & cfg_mask));

  // reserved mode never matches, so a bad setting fails safe
  assign match = (mode == VAM_IP_ANY)  ? 1'b1 :
                 (mode == VAM_IP_HOST) ? host_eq :
                 (mode == VAM_IP_NET)  ? net_eq : 1'b0;

endmodule : vam_ip_cmp

// ---- hdl/vam_matcher.sv ----
// vam_matcher: vlan and arp criteria of one access control entry, apb
// programmed, registered hit/miss per parsed frame.
// assumes header fields are valid for the cycle frm_valid is high.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps

// Notes on behaviour
// - tagged criterion: any, tagged-only or untagged-only
// - tagged criterion resets to any
// - vlan id ignored when its criterion is any
// - specific vlan id limited to 1..4095; hit needs exact equality
// - priority any or 0..7; set value must equal frame priority
// - operation type: any, arp, rarp or other
// - other means opcode is neither known arp nor rarp
// - request setting needs arp or rarp request; any ignores opcode
// - reply setting needs arp or rarp reply
// - sender address ignored when its criterion is any
// - sender host mode needs exact address equality
// - sender network mode uses configured address and mask
// - target address ignored when its criterion is any
// - target host mode needs exact address equality
// - target network mode uses configured address and mask
module vam_matcher
  import vam_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // parsed frame fields
  input  wire logic        frm_valid,
  input  wire logic        frm_tagged,
  input  wire logic [11:0] frm_vid,
  input  wire logic [2:0]  frm_pri,
  input  wire logic [15:0] arp_operation_code,
  input  wire logic [31:0] sender_protocol_address,
  input  wire logic [31:0] frm_target_addr,
  // entry result
  output logic             res_valid,
  output logic             res_hit
);

  // configuration registers
  logic [VAM_CTRL_W-1:0] ctrl_r;
  logic [VAM_VLAN_W-1:0] vlan_r;
  logic [31:0]           saddr_r;
  logic [31:0]           smask_r;
  logic [31:0]           taddr_r;
  logic [31:0]           tmask_r;

  // status and bus answer
  logic                  last_hit_r;
  logic                  last_hit_nxt;
  logic                  rej_r;
  logic                  rej_nxt;
  logic [31:0]           prdata_r;
  logic [31:0]           prdata_nxt;
  logic                  pready_r;
  logic                  pslverr_r;
  logic                  pslverr_nxt;

  // frame result
  logic                  hit_now;
  logic                  res_valid_r;
  logic                  res_hit_r;
  logic                  res_hit_nxt;

  // bus decode
  logic                  acc;
  logic                  acc_end;
  logic                  wr;
  logic                  rd;
  logic                  wr_end;
  logic                  sel_ctl;
  logic                  sel_vln;
  logic                  sel_sad;
  logic                  sel_smk;
  logic                  sel_tad;
  logic                  sel_tmk;
  logic                  sel_sta;
  logic                  mapped;
  logic                  refuse;
  logic                  stat_rd;

  // write enables
  logic                  we_ctl;
  logic                  we_vln;
  logic                  we_sad;
  logic                  we_smk;
  logic                  we_tad;
  logic                  we_tmk;

  // vlan write check
  logic [11:0]           wr_vid;
  logic                  wr_vid_en;
  logic                  vid_bad;
  logic                  vid_rej_acc;
  logic                  vid_rej_end;

  // read words
  logic [31:0]           rd_ctl;
  logic [31:0]           rd_vln;
  logic [31:0]           rd_sta;
  logic [31:0]           rd_mux;

  // criterion fields
  logic [1:0]            tag_mode;
  logic [1:0]            opt_mode;
  logic [1:0]            rr_mode;
  logic [1:0]            snd_mode;
  logic [1:0]            tgt_mode;
  logic [11:0]           cfg_vid;
  logic                  vid_en;
  logic [2:0]            cfg_pri;
  logic                  pri_en;

  // per-criterion results
  logic                  tag_match;
  logic                  vid_match;
  logic                  pri_match;
  logic                  opt_match;
  logic                  rr_match;
  logic                  snd_match;
  logic                  tgt_match;

  // first access cycle launches the answer; the next edge is where
  // the master samples pready, so only the status read-clear lands before it
  assign acc     = psel && penable && !pready_r;
  assign acc_end = psel && penable && pready_r;
  assign wr      = acc && pwrite;
  assign rd      = acc && !pwrite;
  assign wr_end  = acc_end && pwrite;
  assign stat_rd = rd && sel_sta;

  // address decode
  assign sel_ctl = (paddr == VAM_OFS_CTRL);
  assign sel_vln = (paddr == VAM_OFS_VLAN);
  assign sel_sad = (paddr == VAM_OFS_SADDR);
  assign sel_smk = (paddr == VAM_OFS_SMASK);
  assign sel_tad = (paddr == VAM_OFS_TADDR);
  assign sel_tmk = (paddr == VAM_OFS_TMASK);
  assign sel_sta = (paddr == VAM_OFS_STAT);
  assign mapped  = sel_ctl || sel_vln || sel_sad || sel_smk || sel_tad || sel_tmk || sel_sta;

  assign wr_vid      = pwdata[VAM_VLAN_VID_LSB +: 12];
  assign wr_vid_en   = pwdata[VAM_VLAN_VID_EN];
  assign vid_bad     = wr_vid_en && ((wr_vid < VAM_VID_MIN) || (wr_vid > VAM_VID_MAX));
  assign vid_rej_acc = wr && sel_vln && vid_bad;
  assign vid_rej_end = wr_end && sel_vln && vid_bad;

  // refused: unmapped, status write, bad vid
  assign refuse = !mapped || vid_rej_acc || (wr && sel_sta);

  // write enables at the completion edge
  assign we_ctl = wr_end && sel_ctl;
  assign we_vln = wr_end && sel_vln && !vid_bad;
  assign we_sad = wr_end && sel_sad;
  assign we_smk = wr_end && sel_smk;
  assign we_tad = wr_end && sel_tad;
  assign we_tmk = wr_end && sel_tmk;

  // read words and select
  assign rd_ctl = {{(32-VAM_CTRL_W){1'b0}}, ctrl_r};
  assign rd_vln = {{(32-VAM_VLAN_W){1'b0}}, vlan_r};
  assign rd_sta = {30'h00000000, rej_r, last_hit_r};
  assign rd_mux = sel_ctl ? rd_ctl :
                  sel_vln ? rd_vln :
                  sel_sad ? saddr_r :
                  sel_smk ? smask_r :
                  sel_tad ? taddr_r :
                  sel_tmk ? tmask_r :
                  sel_sta ? rd_sta : 32'h00000000;

  // bus answer next values
  assign prdata_nxt  = rd ? rd_mux : 32'h00000000;
  assign pslverr_nxt = acc && refuse;

  // one wait state: pready a cycle after access begins, one-cycle pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= acc;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= VAM_CTRL_RST;
    end else if (we_ctl) begin
      ctrl_r <= pwdata[VAM_CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vlan_r <= VAM_VLAN_RST;
    end else if (we_vln) begin
      vlan_r <= pwdata[VAM_VLAN_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      saddr_r <= VAM_ADDR_RST;
    end else if (we_sad) begin
      saddr_r <= pwdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      smask_r <= VAM_ADDR_RST;
    end else if (we_smk) begin
      smask_r <= pwdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      taddr_r <= VAM_ADDR_RST;
    end else if (we_tad) begin
      taddr_r <= pwdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tmask_r <= VAM_ADDR_RST;
    end else if (we_tmk) begin
      tmask_r <= pwdata;
    end
  end

  // sticky reject; a new reject wins over the read-clear
  assign rej_nxt      = vid_rej_end || (rej_r && !stat_rd);
  assign last_hit_nxt = frm_valid ? hit_now : last_hit_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rej_r      <= 1'b0;
      last_hit_r <= 1'b0;
    end else begin
      rej_r      <= rej_nxt;
      last_hit_r <= last_hit_nxt;
    end
  end

  // criterion fields
  assign tag_mode = ctrl_r[VAM_CTRL_TAG_LSB +: 2];
  assign opt_mode = ctrl_r[VAM_CTRL_OPT_LSB +: 2];
  assign rr_mode  = ctrl_r[VAM_CTRL_RR_LSB +: 2];
  assign snd_mode = ctrl_r[VAM_CTRL_SND_LSB +: 2];
  assign tgt_mode = ctrl_r[VAM_CTRL_TIP_LSB +: 2];
  assign cfg_vid  = vlan_r[VAM_VLAN_VID_LSB +: 12];
  assign vid_en   = vlan_r[VAM_VLAN_VID_EN];
  assign cfg_pri  = vlan_r[VAM_VLAN_PRI_LSB +: 3];
  assign pri_en   = vlan_r[VAM_VLAN_PRI_EN];

  assign tag_match = (tag_mode == VAM_TAG_ANY)    ? 1'b1 :
                     (tag_mode == VAM_TAG_ONLY)   ? frm_tagged :
                     (tag_mode == VAM_UNTAG_ONLY) ? !frm_tagged : 1'b0;

  assign vid_match = !vid_en || (frm_vid == cfg_vid);

  assign pri_match = !pri_en || (frm_pri == cfg_pri);

  vam_opcode_cls u_opcode (
    .opcode    (arp_operation_code),
    .opt_mode  (opt_mode),
    .rr_mode   (rr_mode),
    .opt_match (opt_match),
    .rr_match  (rr_match)
  );

  vam_ip_cmp u_snd_ip (
    .mode     (snd_mode),
    .cfg_addr (saddr_r),
    .cfg_mask (smask_r),
    .frm_addr (sender_protocol_address),
    .match    (snd_match)
  );

  vam_ip_cmp u_tgt_ip (
    .mode     (tgt_mode),
    .cfg_addr (taddr_r),
    .cfg_mask (tmask_r),
    .frm_addr (frm_target_addr),
    .match    (tgt_match)
  );

  assign hit_now = tag_match && vid_match && pri_match && opt_match && rr_match &&
                   snd_match && tgt_match;
  assign res_hit_nxt = frm_valid && hit_now;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      res_valid_r <= 1'b0;
      res_hit_r   <= 1'b0;
    end else begin
      res_valid_r <= frm_valid;
      res_hit_r   <= res_hit_nxt;
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign res_valid = res_valid_r;
  assign res_hit   = res_hit_r;

endmodule : vam_matcher

// ---- hdl/vam_opcode_cls.sv ----
// vam_opcode_cls: classifies an arp operation code against the
// operation-type and request/reply criteria.
// assumes the parser presents the 16-bit opcode as in the frame.
`timescale 1ns/1ps
module vam_opcode_cls
  import vam_pkg::*;
(
  // criterion settings
  input  wire logic [1:0]  opt_mode,
  input  wire logic [1:0]  rr_mode,
  // frame field
  input  wire logic [15:0] opcode,
  // results
  output logic             opt_match,
  output logic             rr_match
);

  logic is_arp;
  logic is_rarp;
  logic is_req;
  logic is_rep;

  assign is_arp  = (opcode == VAM_OP_ARP_REQ)  || (opcode == VAM_OP_ARP_REP);
  assign is_rarp = (opcode == VAM_OP_RARP_REQ) || (opcode == VAM_OP_RARP_REP);
  assign is_req  = (opcode == VAM_OP_ARP_REQ)  || (opcode == VAM_OP_RARP_REQ);
  assign is_rep  = (opcode == VAM_OP_ARP_REP)  || (opcode == VAM_OP_RARP_REP);

  assign opt_match = (opt_mode == VAM_OPT_ANY)  ? 1'b1 :
                     (opt_mode == VAM_OPT_ARP)  ? is_arp :
                     (opt_mode == VAM_OPT_RARP) ? is_rarp :
                     (!is_arp && !is_rarp);

  assign rr_match = (rr_mode == VAM_RR_ANY) ? 1'b1 :
                    (rr_mode == VAM_RR_REQ) ? is_req :
                    (rr_mode == VAM_RR_REP) ? is_rep : 1'b0;

endmodule : vam_opcode_cls

// ---- hdl/vam_pkg.sv ----
// vam_pkg: register map, field layouts, reset values and opcode values
// for the vlan/arp entry matcher; shared by the matcher and its leaves.
package vam_pkg;

  // apb register byte offsets
  localparam logic [7:0] VAM_OFS_CTRL  = 8'h00;
  localparam logic [7:0] VAM_OFS_VLAN  = 8'h04;
  localparam logic [7:0] VAM_OFS_SADDR = 8'h08;
  localparam logic [7:0] VAM_OFS_SMASK = 8'h0C;
  localparam logic [7:0] VAM_OFS_TADDR = 8'h10;
  localparam logic [7:0] VAM_OFS_TMASK = 8'h14;
  localparam logic [7:0] VAM_OFS_STAT  = 8'h18;

  // ctrl register field positions, two bits each
  localparam int VAM_CTRL_TAG_LSB = 0;
  localparam int VAM_CTRL_OPT_LSB = 2;
  localparam int VAM_CTRL_RR_LSB  = 4;
  localparam int VAM_CTRL_SND_LSB = 6;
  localparam int VAM_CTRL_TIP_LSB = 8;
  localparam int VAM_CTRL_W       = 10;

  // vlan register field positions
  localparam int VAM_VLAN_VID_LSB = 0;
  localparam int VAM_VLAN_VID_EN  = 12;
  localparam int VAM_VLAN_PRI_LSB = 13;
  localparam int VAM_VLAN_PRI_EN  = 16;
  localparam int VAM_VLAN_W       = 17;

  // status register field positions
  localparam int VAM_STAT_HIT = 0;
  localparam int VAM_STAT_REJ = 1;

  // reset values: every criterion don't-care
  localparam logic [VAM_CTRL_W-1:0] VAM_CTRL_RST = 10'h000;
  localparam logic [VAM_VLAN_W-1:0] VAM_VLAN_RST = 17'h00000;
  localparam logic [31:0]           VAM_ADDR_RST = 32'h00000000;

  // accepted vlan identifier range
  localparam logic [11:0] VAM_VID_MIN = 12'h001;
  localparam logic [11:0] VAM_VID_MAX = 12'hFFF;

  // arp operation code values
  localparam logic [15:0] VAM_OP_ARP_REQ  = 16'h0001;
  localparam logic [15:0] VAM_OP_ARP_REP  = 16'h0002;
  localparam logic [15:0] VAM_OP_RARP_REQ = 16'h0003;
  localparam logic [15:0] VAM_OP_RARP_REP = 16'h0004;

  typedef enum logic [1:0] {VAM_TAG_ANY, VAM_TAG_ONLY, VAM_UNTAG_ONLY, VAM_TAG_RSV}
    vam_tag_e;
  typedef enum logic [1:0] {VAM_OPT_ANY, VAM_OPT_ARP, VAM_OPT_RARP, VAM_OPT_OTHER}
    vam_opt_e;
  typedef enum logic [1:0] {VAM_RR_ANY, VAM_RR_REQ, VAM_RR_REP, VAM_RR_RSV} vam_rr_e;
  typedef enum logic [1:0] {VAM_IP_ANY, VAM_IP_HOST, VAM_IP_NET, VAM_IP_RSV} vam_ipm_e;

endpackage : vam_pkg

// ---- verification/test_vam_matcher.sv ----
// test_vam_matcher: self-checking bench for the entry matcher.
// assumes vam_frame_src as parser and the checker bound in.
`timescale 1ns/1ps
module test_vam_matcher
  import vam_pkg::*;
;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, sa, ta;
  logic        pready, pslverr, er, frm_valid, frm_tagged, res_valid, res_hit;
  logic [11:0] frm_vid;
  logic [2:0]  frm_pri;
  logic [15:0] opc;
  int          n_errors = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  vam_matcher vam_matcher_inst (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .frm_valid, .frm_tagged, .frm_vid, .frm_pri,
    .arp_operation_code(opc), .sender_protocol_address(sa), .frm_target_addr(ta),
    .res_valid, .res_hit);
  vam_frame_src vam_frame_src_inst (.clk, .frm_valid, .frm_tagged, .frm_vid, .frm_pri,
    .opc, .sa, .ta);
  task tally_and_finish;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // completion is the rising edge at which pready is sampled high
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      n_errors++;
      tally_and_finish;
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task frame(input logic t, input logic [11:0] v, input logic [2:0] p, input logic [15:0] o,
             input logic [31:0] s, input logic [31:0] d, input logic e);
    vam_frame_src_inst.send(t, v, p, o, s, d);
    @(negedge clk);
    cmp({res_valid, res_hit}, {1'b1, e});
  endtask : frame
  task t_reset;
    apb(1'b0, VAM_OFS_CTRL, 32'h0);
    cmp(rd, 32'h0);
    cmp(er, 32'h0);
    apb(1'b0, VAM_OFS_VLAN, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    cmp(er, 32'h1);
    frame(1'b1, 12'h005, 3'h2, 16'h0009, 32'h1, 32'h2, 1'b1);
    $display("t_reset done");
  endtask : t_reset
  task t_tag;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, VAM_OFS_CTRL, 32'(m));
      for (int t = 0; t < 2; t++) frame(1'(t), 12'h001, 3'h0, 16'h0001, 32'h0, 32'h0,
        m == 0 || (m < 3 && t == (m == 1)));
    end
    $display("t_tag done");
  endtask : t_tag
  task t_vlan;
    apb(1'b1, VAM_OFS_CTRL, 32'h0);
    apb(1'b1, VAM_OFS_VLAN, 32'h0000_1000);
    cmp(er, 32'h1);
    apb(1'b1, VAM_OFS_VLAN, 32'h0000_1FFF);
    cmp(er, 32'h0);
    frame(1'b1, 12'hFFF, 3'h0, 16'h0001, 32'h0, 32'h0, 1'b1);
    frame(1'b1, 12'hFFE, 3'h0, 16'h0001, 32'h0, 32'h0, 1'b0);
    apb(1'b1, VAM_OFS_VLAN, 32'h0001_E000);
    frame(1'b1, 12'h005, 3'h7, 16'h0001, 32'h0, 32'h0, 1'b1);
    frame(1'b1, 12'h005, 3'h6, 16'h0001, 32'h0, 32'h0, 1'b0);
    apb(1'b0, VAM_OFS_STAT, 32'h0);
    cmp(rd, 32'h2);
    apb(1'b0, VAM_OFS_STAT, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b1, VAM_OFS_STAT, 32'h3);
    cmp(er, 32'h1);
    apb(1'b1, VAM_OFS_VLAN, 32'h0);
    $display("t_vlan done");
  endtask : t_vlan
  task t_opcode;
    logic e;
    for (int f = 0; f < 2; f++) for (int m = 0; m < 4; m++) begin
      apb(1'b1, VAM_OFS_CTRL, 32'(m << (2 + 2 * f)));
      for (int o = 0; o < 6; o++) begin
        e = f ? (m == 0 || (m == 1 && o % 2 == 1 && o < 4) || (m == 2 && (o == 2 || o == 4)))
              : (m == 0 || (m == 1 && (o == 1 || o == 2)) || (m == 2 && (o == 3 || o == 4))
                 || (m == 3 && (o < 1 || o > 4)));
        frame(1'b0, 12'h001, 3'h0, 16'(o), 32'h0, 32'h0, e);
      end
    end
    $display("t_opcode done");
  endtask : t_opcode
  task t_ip;
    logic [7:0]  b;
    logic [31:0] h, x;
    for (int k = 0; k < 4; k++) begin
      b = k[0] ? VAM_OFS_TADDR : VAM_OFS_SADDR;
      h = k[1] ? 32'hC0A800FE : 32'hC0A80001;
      x = k[1] ? 32'hC0A801FE : 32'hC0A80000;
      apb(1'b1, b, 32'hC0A80001);
      apb(1'b1, b + 8'h04, 32'hFFFFFF00);
      apb(1'b1, VAM_OFS_CTRL, 32'((k / 2 + 1) << (6 + 2 * (k % 2))));
      frame(1'b0, 12'h001, 3'h0, 16'h1, k[0] ? ~h : h, k[0] ? h : ~h, 1'b1);
      frame(1'b0, 12'h001, 3'h0, 16'h1, k[0] ? h : x, k[0] ? x : h, 1'b0);
    end
    $display("t_ip done");
  endtask : t_ip
  task t_rst2;
    apb(1'b1, VAM_OFS_CTRL, 32'h0000_0155);
    apb(1'b0, VAM_OFS_CTRL, 32'h0);
    cmp(rd, 32'h0000_0155);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, VAM_OFS_CTRL, 32'h0);
    cmp(rd, 32'h0);
    frame(1'b0, 12'h003, 3'h1, 16'h0002, 32'h5, 32'h6, 1'b1);
    $display("t_rst2 done");
  endtask : t_rst2
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_tag;
    t_vlan;
    t_opcode;
    t_ip;
    t_rst2;
    tally_and_finish;
  end
endmodule : test_vam_matcher

// ---- verification/vam_frame_src.sv ----
// vam_frame_src: ingress parser stand-in, one frame per send call.
// assumes a single bench process calls send.
`timescale 1ns/1ps
module vam_frame_src (
  // clock
  input wire logic    clk,
  // parsed fields
  output logic        frm_valid,
  output logic        frm_tagged,
  output logic [11:0] frm_vid,
  output logic [2:0]  frm_pri,
  output logic [15:0] opc,
  output logic [31:0] sa,
  output logic [31:0] ta
);
  initial {frm_valid, frm_tagged, frm_vid, frm_pri, opc, sa, ta} = '0;
  // fields invert off-frame so stale values never pass for valid ones
  task send(input logic t, input logic [11:0] v, input logic [2:0] p,
            input logic [15:0] o, input logic [31:0] s, input logic [31:0] d);
    @(posedge clk);
    frm_valid <= 1'b1;
    {frm_tagged, frm_vid, frm_pri, opc, sa, ta} <= {t, v, p, o, s, d};
    @(posedge clk);
    frm_valid <= 1'b0;
    {frm_tagged, frm_vid, frm_pri, opc, sa, ta} <= ~{t, v, p, o, s, d};
  endtask : send
endmodule : vam_frame_src

// ---- verification/vam_matcher_properties.sv ----
// vam_matcher_properties: port-level checks on the entry matcher.
// assumes it is bound onto vam_matcher and sees only its ports.
`timescale 1ns/1ps
module vam_matcher_properties
  import vam_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // frame and result
  input wire logic        frm_valid,
  input wire logic        res_valid,
  input wire logic        res_hit
);
  logic touched_r;
  wire  acc = psel && penable && !pready;
  wire  vid_wr = acc && pwrite && paddr == VAM_OFS_VLAN && pwdata[12];
  // any write ends the all-default phase; zero writes too, to stay safe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      touched_r <= 1'b0;
    end else if (acc && pwrite) begin
      touched_r <= 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_res_lat; frm_valid |=> res_valid; endproperty
  a_res_lat: assert property (p_res_lat) else $error("frame gave no result");
  property p_res_cause; res_valid |-> $past(frm_valid); endproperty
  a_res_cause: assert property (p_res_cause) else $error("result without frame");
  property p_hit_qual; res_hit |-> res_valid; endproperty
  a_hit_qual: assert property (p_hit_qual) else $error("hit outside result");
  property p_dflt; res_valid && !touched_r |-> res_hit; endproperty
  a_dflt: assert property (p_dflt) else $error("default entry missed");
  property p_rdy; acc |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("bad ready pulse");
  property p_rdy_cause; pready |-> $past(acc); endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready without access");
  property p_vid0; vid_wr && pwdata[11:0] == 12'h000 |=> pslverr; endproperty
  a_vid0: assert property (p_vid0) else $error("vid zero accepted");
  property p_vid_ok; vid_wr && pwdata[11:0] != 12'h000 |=> !pslverr; endproperty
  a_vid_ok: assert property (p_vid_ok) else $error("legal vid refused");
  property p_err_qual; pslverr |-> pready; endproperty
  a_err_qual: assert property (p_err_qual) else $error("error outside ready");
endmodule : vam_matcher_properties

bind vam_matcher vam_matcher_properties vam_matcher_properties_inst (.clk, .nrst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .frm_valid, .res_valid, .res_hit);
